/* File: hw/cms_mailbox_locks.sv */
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module cms_mailbox_locks (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_src,
	output logic [31:0] o_rdata,
	// soft interrupts toward the local processor
	output logic [1:0] o_cpu_irq,
	// soft interrupts toward the external interrupt pins
	output logic [1:0] o_ext_irq
);

	// mailbox word
	logic [31:0] mbox;
	// per-lock holder code, zero when free
	logic [2:0] holder [0:1];
	// interrupt polarity, one bit per lock
	logic [1:0] lock_irq_polarity;
	// manual trigger levels, one per soft interrupt
	logic [1:0] irq_manual_trigger;
	// route select, 0 local, 1 external
	logic [1:0] irq_route;
	// read data return state
	cms_pkg::cms_rd_type rd_state;
	// combinational read mux result
	logic [31:0] next_rdata;
	// holder code for the current requester
	logic [2:0] src_holder;
	// per-lock take and release strobes
	logic [1:0] take_hit;
	logic [1:0] rel_hit;
	// per-lock free flag
	logic [1:0] lock_free;
	// raw soft interrupt levels
	logic [1:0] soft_level;

	// map access source to a holder code
	always_comb begin
		// each of the four access sources maps to its own holder code
		case (i_src)
			cms_pkg::SRC_LOCAL_CPU: begin
				src_holder = cms_pkg::HOLDER_LOCAL_CPU;
			end
			cms_pkg::SRC_PARALLEL_HOST: begin
				src_holder = cms_pkg::HOLDER_PARALLEL_HOST;
			end
			cms_pkg::SRC_SERIAL_HOST: begin
				src_holder = cms_pkg::HOLDER_SERIAL_HOST;
			end
			cms_pkg::SRC_MGMT_SERIAL: begin
				src_holder = cms_pkg::HOLDER_MGMT_SERIAL;
			end
			default: begin
				src_holder = cms_pkg::HOLDER_FREE;
			end
		endcase
	end

	// mailbox update: full write, masked set, masked clear
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			mbox <= cms_pkg::MBOX_RST;
		end else if (i_wr) begin
			case (i_addr)
				cms_pkg::OFS_MBOX: begin
					mbox <= i_wdata;
				end
				cms_pkg::OFS_MBOX_SET: begin
					mbox <= mbox | i_wdata;
				end
				cms_pkg::OFS_MBOX_BIT_CLEAR_PORT: begin
					mbox <= mbox & ~i_wdata;
				end
				default: begin
					mbox <= mbox;
				end
			endcase
		end
	end

	// per-lock logic, one copy per lock
	genvar g;
	generate
		for (g = 0; g < cms_pkg::LOCK_N; g = g + 1) begin : g_lock
			// this lock's take field offset
			localparam logic [7:0] TAKE_OFS = cms_pkg::OFS_LOCK0_TAKE + 8'(4 * g);

			// decode take read and release write for this lock only
			assign take_hit[g] = i_rd && (i_addr == TAKE_OFS);
			assign rel_hit[g] = i_wr && (i_addr == TAKE_OFS) &&
				i_wdata[cms_pkg::TAKE_BIT];
			assign lock_free[g] = (holder[g] == cms_pkg::HOLDER_FREE);

			// holder register: take on free read, release on write of 1
			always_ff @(posedge i_clock or posedge i_rst) begin
				if (i_rst) begin
					holder[g] <= cms_pkg::HOLDER_FREE;
				end else if (rel_hit[g]) begin
					// release accepted from any source
					holder[g] <= cms_pkg::HOLDER_FREE;
				end else if (take_hit[g] && lock_free[g]) begin
					// free lock: reader becomes holder
					holder[g] <= src_holder;
				end else begin
					// held lock: ownership untouched
					holder[g] <= holder[g];
				end
			end

			// raw interrupt level from state and polarity
			always_comb begin
				if (lock_irq_polarity[g]) begin
					soft_level[g] = !lock_free[g];
				end else begin
					soft_level[g] = lock_free[g];
				end
			end

			// routed and forced interrupt outputs, registered
			always_ff @(posedge i_clock or posedge i_rst) begin
				if (i_rst) begin
					o_cpu_irq[g] <= 1'b0;
					o_ext_irq[g] <= 1'b0;
				end else begin
					// lock g feeds soft interrupt g only
					o_cpu_irq[g] <= !irq_route[g] &&
						(soft_level[g] || irq_manual_trigger[g]);
					o_ext_irq[g] <= irq_route[g] &&
						(soft_level[g] || irq_manual_trigger[g]);
				end
			end
		end
	endgenerate

	// configuration registers written by software
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			lock_irq_polarity <= cms_pkg::POL_RST;
			irq_manual_trigger <= cms_pkg::FORCE_RST;
			irq_route <= cms_pkg::ROUTE_RST;
		end else if (i_wr) begin
			// polarity select
			if (i_addr == cms_pkg::OFS_LOCK_IRQ_CONFIG) begin
				lock_irq_polarity <= i_wdata[cms_pkg::POL_BIT0 +: 2];
			end
			// manual trigger levels
			if (i_addr == cms_pkg::OFS_IRQ_MANUAL_TRIGGER) begin
				irq_manual_trigger <= i_wdata[cms_pkg::FORCE_BIT0 +: 2];
			end
			// route select
			if (i_addr == cms_pkg::OFS_IRQ_ROUTE) begin
				irq_route <= i_wdata[cms_pkg::ROUTE_BIT0 +: 2];
			end
		end
	end

	// read mux, sampled against state before this cycle's update
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (i_addr)
			cms_pkg::OFS_MBOX, cms_pkg::OFS_MBOX_SET,
			cms_pkg::OFS_MBOX_BIT_CLEAR_PORT: begin
				// every mailbox port reads back the word
				next_rdata = mbox;
			end
			cms_pkg::OFS_LOCK_IRQ_CONFIG: begin
				next_rdata = {30'h0000_0000, lock_irq_polarity};
			end
			cms_pkg::OFS_LOCK0_TAKE: begin
				// one for a read of a free lock, which takes it unless a release writes in the same cycle
				next_rdata = {31'h0000_0000, lock_free[0]};
			end
			cms_pkg::OFS_LOCK1_TAKE: begin
				next_rdata = {31'h0000_0000, lock_free[1]};
			end
			cms_pkg::OFS_LOCK0_HOLDER: begin
				next_rdata = {29'h0000_0000, holder[0]};
			end
			cms_pkg::OFS_LOCK1_HOLDER: begin
				next_rdata = {29'h0000_0000, holder[1]};
			end
			cms_pkg::OFS_IRQ_MANUAL_TRIGGER: begin
				next_rdata = {30'h0000_0000, irq_manual_trigger};
			end
			cms_pkg::OFS_IRQ_ROUTE: begin
				next_rdata = {30'h0000_0000, irq_route};
			end
			default: begin
				// unmapped offsets read zero
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// read data stands one cycle after the strobe and only then
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
			rd_state <= cms_pkg::CMS_IDLE;
		end else begin
			case (rd_state)
				cms_pkg::CMS_IDLE: begin
					if (i_rd) begin
						o_rdata <= next_rdata;
						rd_state <= cms_pkg::CMS_ANSWER;
					end else begin
						o_rdata <= 32'h0000_0000;
					end
				end
				cms_pkg::CMS_ANSWER: begin
					// back-to-back reads keep answering
					if (i_rd) begin
						o_rdata <= next_rdata;
					end else begin
						o_rdata <= 32'h0000_0000;
						rd_state <= cms_pkg::CMS_IDLE;
					end
				end
				default: begin
					o_rdata <= 32'h0000_0000;
					rd_state <= cms_pkg::CMS_IDLE;
				end
			endcase
		end
	end

endmodule

/* File: pkg/cms_pkg.sv */
// shared constants for the mailbox and lock block
package cms_pkg;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LOCK_N = 2;
	localparam int SRC_W = 2;
	localparam int HOLDER_W = 3;

	// register byte offsets
	localparam logic [7:0] OFS_MBOX_SET = 8'h00;
	localparam logic [7:0] OFS_MBOX_BIT_CLEAR_PORT = 8'h04;
	localparam logic [7:0] OFS_MBOX = 8'h08;
	localparam logic [7:0] OFS_LOCK_IRQ_CONFIG = 8'h0C;
	localparam logic [7:0] OFS_LOCK0_TAKE = 8'h10;
	localparam logic [7:0] OFS_LOCK1_TAKE = 8'h14;
	localparam logic [7:0] OFS_LOCK0_HOLDER = 8'h18;
	localparam logic [7:0] OFS_LOCK1_HOLDER = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MANUAL_TRIGGER = 8'h20;
	localparam logic [7:0] OFS_IRQ_ROUTE = 8'h24;

	// field positions
	localparam int TAKE_BIT = 0;
	localparam int POL_BIT0 = 0;
	localparam int FORCE_BIT0 = 0;
	localparam int ROUTE_BIT0 = 0;

	// reset values
	localparam logic [31:0] MBOX_RST = 32'h0000_0000;
	localparam logic [2:0] HOLDER_FREE = 3'h0;
	localparam logic [1:0] POL_RST = 2'h0;
	localparam logic [1:0] FORCE_RST = 2'h0;
	localparam logic [1:0] ROUTE_RST = 2'h0;

	// access source identities
	localparam logic [1:0] SRC_LOCAL_CPU = 2'h0;
	localparam logic [1:0] SRC_PARALLEL_HOST = 2'h1;
	localparam logic [1:0] SRC_SERIAL_HOST = 2'h2;
	localparam logic [1:0] SRC_MGMT_SERIAL = 2'h3;

	// holder codes
	localparam logic [2:0] HOLDER_LOCAL_CPU = 3'h1;
	localparam logic [2:0] HOLDER_PARALLEL_HOST = 3'h2;
	localparam logic [2:0] HOLDER_SERIAL_HOST = 3'h3;
	localparam logic [2:0] HOLDER_MGMT_SERIAL = 3'h4;

	// read state of the data return path
	typedef enum logic [0:0] {
		CMS_IDLE,
		CMS_ANSWER
	} cms_rd_type;

endpackage

/* File: verif/cms_host_model.sv */
`timescale 1ns/100ps
// bus master standing in for the processors
module cms_host_model (
	// clock and read data
	input wire logic i_clock,
	input wire logic [31:0] i_rdata,
	// bus request
	output logic [7:0] o_addr,
	output logic [31:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	output logic [1:0] o_src
);
	// idle bus at time zero
	initial begin
		o_addr = 8'h0;
		o_wdata = 32'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_src = 2'h0;
	end
	// one-cycle write, then scramble the idle bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s);
		@(posedge i_clock);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		o_src <= s;
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// one-cycle read, data taken in the next cycle
	task automatic rd(input logic [7:0] a, input logic [1:0] s, output logic [31:0] q);
		@(posedge i_clock);
		o_rd <= 1'b1;
		o_addr <= a;
		o_src <= s;
		@(posedge i_clock);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		q = i_rdata;
	endtask
endmodule

/* File: verif/cms_mailbox_locks_assertions.sv */
`timescale 1ns/100ps
// watches the register port and irq outputs
module cms_checker (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_src,
	input wire logic [31:0] o_rdata,
	// soft irqs
	input wire logic [1:0] o_cpu_irq,
	input wire logic [1:0] o_ext_irq
);
	logic [1:0] free; // shadow of lock state
	// shadow follows takes and releases
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) free <= 2'h3;
		else begin
			if (i_rd && i_addr == cms_pkg::OFS_LOCK0_TAKE) free[0] <= 1'b0;
			if (i_wr && i_addr == cms_pkg::OFS_LOCK0_TAKE && i_wdata[0]) free[0] <= 1'b1;
			if (i_rd && i_addr == cms_pkg::OFS_LOCK1_TAKE) free[1] <= 1'b0;
			if (i_wr && i_addr == cms_pkg::OFS_LOCK1_TAKE && i_wdata[0]) free[1] <= 1'b1;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero when idle");
	AST_LOCK0: assert property (i_rd && i_addr == cms_pkg::OFS_LOCK0_TAKE
		|=> o_rdata == {31'h0, $past(free[0])}) else $error("lock0 take result wrong");
	AST_LOCK1: assert property (i_rd && i_addr == cms_pkg::OFS_LOCK1_TAKE
		|=> o_rdata == {31'h0, $past(free[1])}) else $error("lock1 take result wrong");
	AST_HOLD_FREE: assert property (i_rd && i_addr == cms_pkg::OFS_LOCK0_HOLDER && free[0]
		|=> o_rdata == 32'h0) else $error("free lock shows a holder");
	AST_HOLD_CODE: assert property (i_rd && i_addr == cms_pkg::OFS_LOCK1_HOLDER && !free[1]
		|=> o_rdata >= 32'h1 && o_rdata <= 32'h4) else $error("taken lock holder code bad");
	AST_ROUTE_EXCL: assert property ((o_cpu_irq & o_ext_irq) == 2'h0)
		else $error("irq on both routes");
	AST_UNMAPPED: assert property (i_rd && i_addr > cms_pkg::OFS_IRQ_ROUTE
		|=> o_rdata == 32'h0) else $error("unmapped read not zero");
	AST_RELEASE: assert property (i_wr && i_addr == cms_pkg::OFS_LOCK0_TAKE && i_wdata[0]
		##1 !i_rd ##1 i_rd && i_addr == cms_pkg::OFS_LOCK0_TAKE |=> o_rdata == 32'h1)
		else $error("released lock not takeable");
endmodule
bind cms_mailbox_locks cms_checker cms_checker_inst (.i_clock(i_clock), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_src(i_src),
	.o_rdata(o_rdata), .o_cpu_irq(o_cpu_irq), .o_ext_irq(o_ext_irq));

/* File: verif/tb.sv */
`timescale 1ns/100ps
// register-level test of the mailbox and locks
module tb;
	logic i_clock, i_rst, wr, rd; // clock, reset, strobes
	logic [7:0] addr; // bus address
	logic [31:0] wdata, rdata, q; // bus data
	logic [1:0] src, cpu_irq, ext_irq; // source and irqs
	int n_fail, checks_done; // counters
	// 250 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	cms_host_model cms_host_model_inst (.i_clock(i_clock), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_src(src));
	cms_mailbox_locks cms_mailbox_locks_inst (.i_clock(i_clock), .i_rst(i_rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_src(src), .o_rdata(rdata),
		.o_cpu_irq(cpu_irq), .o_ext_irq(ext_irq));
	// compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict
	task tally_and_finish;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// read and compare
	task rc(input logic [7:0] a, input logic [1:0] s, input logic [31:0] exp);
		cms_host_model_inst.rd(a, s, q);
		check(q, exp);
	endtask
	// irq levels as {ext, cpu}
	task irq(input logic [3:0] exp);
		repeat (2) @(posedge i_clock);
		#1;
		check({28'h0, ext_irq, cpu_irq}, {28'h0, exp});
	endtask
	// cut a hang short
	initial begin
		#20000;
		n_fail++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		n_fail = 0;
		checks_done = 0;
		i_rst = 1'b1;
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		rc(cms_pkg::OFS_MBOX, 2'h0, 32'h0);
		rc(cms_pkg::OFS_LOCK0_HOLDER, 2'h0, 32'(cms_pkg::HOLDER_FREE));
		irq(4'h3);
		cms_host_model_inst.wr(cms_pkg::OFS_MBOX, 32'hA5A5_0F0F, 2'h1);
		rc(cms_pkg::OFS_MBOX, 2'h2, 32'hA5A5_0F0F);
		cms_host_model_inst.wr(cms_pkg::OFS_MBOX_SET, 32'hF000_0000, 2'h2);
		rc(cms_pkg::OFS_MBOX, 2'h0, 32'hF5A5_0F0F);
		cms_host_model_inst.wr(cms_pkg::OFS_MBOX_BIT_CLEAR_PORT, 32'h0000_000F, 2'h3);
		rc(cms_pkg::OFS_MBOX, 2'h0, 32'hF5A5_0F00);
		// each source takes both locks, is refused lock0, frees lock1 itself and has lock0 released by another
		for (int k = 0; k < 4; k++) begin
			rc(cms_pkg::OFS_LOCK0_TAKE, 2'(k), 32'h1);
			rc(cms_pkg::OFS_LOCK0_HOLDER, 2'(k), 32'(cms_pkg::HOLDER_LOCAL_CPU) + k);
			cms_host_model_inst.wr(cms_pkg::OFS_LOCK0_TAKE, 32'hFFFF_FFFE, 2'(k));
			rc(cms_pkg::OFS_LOCK0_TAKE, 2'(k), 32'h0);
			rc(cms_pkg::OFS_LOCK0_TAKE, 2'(k + 1), 32'h0);
			rc(cms_pkg::OFS_LOCK1_TAKE, 2'(k), 32'h1);
			rc(cms_pkg::OFS_LOCK1_HOLDER, 2'(k), 32'(cms_pkg::HOLDER_LOCAL_CPU) + k);
			cms_host_model_inst.wr(cms_pkg::OFS_LOCK1_TAKE, 32'h1, 2'(k));
			cms_host_model_inst.wr(cms_pkg::OFS_LOCK0_TAKE, 32'h1, 2'(k + 1));
			rc(cms_pkg::OFS_LOCK0_HOLDER, 2'(k), 32'h0);
		end
		// release of a free lock, then a take right behind it
		cms_host_model_inst.wr(cms_pkg::OFS_LOCK0_TAKE, 32'h1, 2'h3);
		rc(cms_pkg::OFS_LOCK0_TAKE, 2'h0, 32'h1);
		irq(4'h2);
		cms_host_model_inst.wr(cms_pkg::OFS_LOCK_IRQ_CONFIG, 32'h3, 2'h0);
		irq(4'h1);
		cms_host_model_inst.wr(cms_pkg::OFS_IRQ_ROUTE, 32'h1, 2'h0);
		irq(4'h4);
		cms_host_model_inst.wr(cms_pkg::OFS_IRQ_MANUAL_TRIGGER, 32'h2, 2'h0);
		irq(4'h6);
		cms_host_model_inst.wr(8'h30, 32'hFFFF_FFFF, 2'h0);
		rc(8'h30, 2'h0, 32'h0);
		// second reset in mid-run
		@(posedge i_clock);
		i_rst <= 1'b1;
		@(posedge i_clock);
		i_rst <= 1'b0;
		rc(cms_pkg::OFS_MBOX, 2'h0, 32'h0);
		rc(cms_pkg::OFS_LOCK0_TAKE, 2'h0, 32'h1);
		irq(4'h2);
		tally_and_finish();
	end
endmodule
